/* File: logic/ssp_link_if.sv */
// Synchronised link events passed from the pin synchroniser to the port core
`default_nettype none

interface ssp_link_if;
  logic sel_n;
  logic sel_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic sdi;

  modport sync (output sel_n, output sel_rise, output sclk_rise, output sclk_fall, output sdi);
  modport core (input sel_n, input sel_rise, input sclk_rise, input sclk_fall, input sdi);
endinterface : ssp_link_if

`default_nettype wire

/* File: logic/ssp_link_sync.sv */
// Two-stage synchroniser for the select, clock and data pins, with edge finders for select and clock only
`default_nettype none
`include "ssp_params.svh"

module ssp_link_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Port enable and raw pins
  input wire logic port_enable,
  input wire logic pin_select_n,
  input wire logic pin_clk,
  input wire logic pin_serial_in,
  // Events to the core
  ssp_link_if.sync lnk
);
  import ssp_pkg::*;

  logic [2:0] raw;
  logic [2:0] stage1;
  logic [2:0] stage2;
  logic [2:0] last;
  logic sel_gated;

  // Pins go straight into the first stage; no logic ahead of it
  assign raw = {pin_select_n, pin_clk, pin_serial_in};
  // A disabled port looks permanently deselected
  assign sel_gated = port_enable ? stage2[2] : 1'b1;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= 3'h4;
      stage2 <= 3'h4;
      last <= 3'h4;
    end else if (clk_en) begin
      stage1 <= raw;
      stage2 <= stage1;
      last <= {sel_gated, stage2[1:0]};
    end
  end

  assign lnk.sel_n = last[2];
  assign lnk.sel_rise = sel_gated & ~last[2];
  assign lnk.sclk_rise = stage2[1] & ~last[1];
  assign lnk.sclk_fall = ~stage2[1] & last[1];
  assign lnk.sdi = stage2[0];

endmodule : ssp_link_sync

`default_nettype wire

/* File: logic/ssp_params.svh */
// Constants of the serial slave memory port: encodings, addresses, reset values, pin map
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// Field widths
`define SSP_CMD_BITS 8
`define SSP_ADDR_BITS 16
`define SSP_BYTE_BITS 8

// Command encodings (top two bits, and the two quiet command values)
`define SSP_OPC_READ 2'b11
`define SSP_OPC_WRITE 2'b10
`define SSP_RD_QUIET 8'hc0
`define SSP_WR_QUIET 8'h80

// I/O register region that the processor may hold
`define SSP_IO_BASE 16'h2000
`define SSP_IO_LIMIT 16'h20ff

// Byte returned for a read the processor refused
`define SSP_IO_FAIL_BYTE 8'h00

// Reset values
`define SSP_CMD_RST 8'h00
`define SSP_ADDR_RST 16'h0000

// Shared pin map: a = select, b = serial clock, c = serial in, d = serial out
`define SSP_PIN_SEL 0
`define SSP_PIN_CLK 1
`define SSP_PIN_SDI 2
`define SSP_PIN_SDO 3
`define SSP_PIN_COUNT 4

// Host bit rate limits, kb/s, and system clock in kHz
`define SSP_RATE_MISSION_KBPS 1000
`define SSP_RATE_BROWNOUT_KBPS 16
`define SSP_CLK_KHZ 50000

`endif

/* File: logic/ssp_pkg.sv */
// Types and decode helpers of the serial slave memory port
`default_nettype none
`include "ssp_params.svh"

package ssp_pkg;

  typedef enum logic [1:0] {SSP_PH_CMD, SSP_PH_ADDR, SSP_PH_DATA} ssp_phase_t;

  typedef enum logic [1:0] {SSP_OP_NONE, SSP_OP_RD, SSP_OP_WR} ssp_op_t;

  function automatic ssp_op_t ssp_op_of(input logic [1:0] top);
    ssp_op_t op;
    op = SSP_OP_NONE;
    if (top == `SSP_OPC_READ) begin
      op = SSP_OP_RD;
    end else if (top == `SSP_OPC_WRITE) begin
      op = SSP_OP_WR;
    end
    return op;
  endfunction : ssp_op_of

  function automatic logic ssp_is_io_addr(input logic [15:0] a);
    return (a >= `SSP_IO_BASE) && (a <= `SSP_IO_LIMIT);
  endfunction : ssp_is_io_addr

endpackage : ssp_pkg

`default_nettype wire

/* File: logic/ssp_slave_port.sv */
// Serial slave port giving an external host byte access to the data memory space
`default_nettype none
`include "ssp_params.svh"

module ssp_slave_port #(
  parameter int ADDR_W = `SSP_ADDR_BITS
) (
  // Clock, reset, clock enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Configuration and arbitration
  input wire logic slave_port_enable,
  input wire logic io_bus_busy,
  // Shared LCD segment pins
  input wire logic [`SSP_PIN_COUNT-1:0] lcd_seg_drive,
  input wire logic [`SSP_PIN_COUNT-1:0] seg_pin_in,
  output logic [`SSP_PIN_COUNT-1:0] seg_pin_out,
  output logic [`SSP_PIN_COUNT-1:0] seg_pin_oe_n,
  // Data memory bus
  output logic mem_req,
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [`SSP_BYTE_BITS-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [`SSP_BYTE_BITS-1:0] mem_rdata,
  // Processor status
  output logic [`SSP_CMD_BITS-1:0] last_command_reg,
  output logic [ADDR_W-1:0] last_address_reg,
  output logic host_command_irq,
  output logic port_irq
);
  import ssp_pkg::*;

  // Counter is four bits and the I/O decode is sixteen
  if (ADDR_W < `SSP_BYTE_BITS + 1 || ADDR_W > `SSP_ADDR_BITS) begin : g_bad_width
    $error("ssp_slave_port: ADDR_W must lie between 9 and 16");
  end

  // Serial out must be the top pin for the pin mux below
  if (`SSP_PIN_SDO != `SSP_PIN_COUNT - 1) begin : g_bad_pins
    $error("ssp_slave_port: serial out must be the last shared pin");
  end

  localparam logic [3:0] CMD_LAST = 4'(`SSP_CMD_BITS - 1);
  localparam logic [3:0] ADDR_LAST = 4'(ADDR_W - 1);
  localparam logic [3:0] BYTE_LAST = 4'(`SSP_BYTE_BITS - 1);

  ssp_link_if lnk ();

  // Pins pass the synchroniser before any decode sees them
  ssp_link_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .port_enable(slave_port_enable),
    .pin_select_n(seg_pin_in[`SSP_PIN_SEL]),
    .pin_clk(seg_pin_in[`SSP_PIN_CLK]),
    .pin_serial_in(seg_pin_in[`SSP_PIN_SDI]),
    .lnk(lnk.sync)
  );

  ssp_phase_t phase;
  ssp_op_t op;
  logic [3:0] bit_cnt;
  logic [ADDR_W-1:0] rx;
  logic [ADDR_W-1:0] cur_addr;
  logic addr_valid;
  logic [`SSP_BYTE_BITS-1:0] tx;
  logic [`SSP_BYTE_BITS-1:0] rd_buf;

  // Link event decode
  wire active;
  wire rise;
  wire fall;
  wire cmd_done;
  wire addr_done;
  wire byte_done;
  wire [ADDR_W-1:0] rx_next;
  wire [ADDR_W-1:0] addr_inc;
  wire [3:0] next_cnt;
  ssp_phase_t next_phase;
  ssp_op_t cmd_op;

  assign active = ~lnk.sel_n;
  assign rise = active & lnk.sclk_rise;
  assign fall = active & lnk.sclk_fall;
  assign rx_next = {rx[ADDR_W-2:0], lnk.sdi};
  assign cmd_done = rise && phase == SSP_PH_CMD && bit_cnt == CMD_LAST;
  assign addr_done = rise && phase == SSP_PH_ADDR && bit_cnt == ADDR_LAST;
  assign byte_done = rise && phase == SSP_PH_DATA && bit_cnt == BYTE_LAST;
  assign addr_inc = ADDR_W'(cur_addr + 1'b1);
  assign next_cnt = (cmd_done || addr_done || byte_done) ? 4'h0 : 4'(bit_cnt + 1'b1);
  assign next_phase = cmd_done ? SSP_PH_ADDR : (addr_done ? SSP_PH_DATA : phase);
  assign cmd_op = ssp_op_of(rx_next[`SSP_CMD_BITS-1:`SSP_CMD_BITS-2]);

  // Memory access decode
  wire fetch;
  wire store;
  wire issue;
  wire io_blocked;
  wire [ADDR_W-1:0] bus_addr;

  assign fetch = (op == SSP_OP_RD) && (addr_done || byte_done);
  assign store = (op == SSP_OP_WR) && byte_done;
  assign issue = fetch | store;
  assign bus_addr = store ? cur_addr : (addr_done ? rx_next : addr_inc);
  assign io_blocked = ssp_is_io_addr(16'(bus_addr)) & io_bus_busy;

  // Serial out: a read byte is loaded on the falling edge just before the first rising edge of each byte slot
  wire load_tx;
  wire [`SSP_BYTE_BITS-1:0] next_tx;

  assign load_tx = fall && phase == SSP_PH_DATA && bit_cnt == 4'h0 && op == SSP_OP_RD;
  assign next_tx = load_tx ? rd_buf : (fall ? {tx[`SSP_BYTE_BITS-2:0], 1'b0} : tx);

  // Bit and phase tracking; deselect returns to the command phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase <= SSP_PH_CMD;
      bit_cnt <= 4'h0;
      rx <= '0;
    end else if (clk_en) begin
      if (lnk.sel_n) begin
        phase <= SSP_PH_CMD;
        bit_cnt <= 4'h0;
        rx <= '0;
      end else if (rise) begin
        rx <= rx_next;
        bit_cnt <= next_cnt;
        phase <= next_phase;
      end
    end
  end

  // Operation of the current frame; a partial frame leaves none
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op <= SSP_OP_NONE;
      addr_valid <= 1'b0;
    end else if (clk_en) begin
      if (lnk.sel_n) begin
        op <= SSP_OP_NONE;
        addr_valid <= 1'b0;
      end else begin
        if (cmd_done) begin
          op <= cmd_op;
        end
        if (addr_done) begin
          addr_valid <= 1'b1;
        end
      end
    end
  end

  // Serial out shifter, cleared while deselected
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx <= '0;
    end else if (clk_en) begin
      if (lnk.sel_n) begin
        tx <= '0;
      end else begin
        tx <= next_tx;
      end
    end
  end

  // Running address survives deselect long enough to be reported
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cur_addr <= '0;
    end else if (clk_en) begin
      if (addr_done) begin
        cur_addr <= rx_next;
      end else if (byte_done && op != SSP_OP_NONE) begin
        cur_addr <= addr_inc;
      end
    end
  end

  // Memory bus: shared without arbitration, I/O accesses dropped when refused
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= '0;
    end else if (clk_en) begin
      if (issue && !io_blocked) begin
        mem_req <= 1'b1;
        mem_we <= store;
        mem_addr <= bus_addr;
        mem_wdata <= rx_next[`SSP_BYTE_BITS-1:0];
      end else if (mem_ack) begin
        mem_req <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_buf <= '0;
    end else if (clk_en) begin
      if (fetch && io_blocked) begin
        rd_buf <= `SSP_IO_FAIL_BYTE;
      end else if (mem_ack && mem_req && !mem_we) begin
        rd_buf <= mem_rdata;
      end
    end
  end

  // Processor status and interrupt pulses
  wire quiet_cmd;
  wire next_port_irq;

  assign quiet_cmd = (op == SSP_OP_RD && last_command_reg == `SSP_RD_QUIET) ||
                     (op == SSP_OP_WR && last_command_reg == `SSP_WR_QUIET);
  assign next_port_irq = lnk.sel_rise && op != SSP_OP_NONE && !quiet_cmd;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_command_reg <= `SSP_CMD_RST;
      last_address_reg <= ADDR_W'(`SSP_ADDR_RST);
      host_command_irq <= 1'b0;
      port_irq <= 1'b0;
    end else if (clk_en) begin
      host_command_irq <= cmd_done;
      port_irq <= next_port_irq;
      if (cmd_done) begin
        last_command_reg <= rx_next[`SSP_CMD_BITS-1:0];
      end
      if (lnk.sel_rise && addr_valid) begin
        last_address_reg <= cur_addr;
      end
    end
  end

  // Pin mux: LCD drive by default, serial output floats while deselected
  wire [`SSP_PIN_COUNT-1:0] port_pin_out;
  wire [`SSP_PIN_COUNT-1:0] port_pin_oe_n;
  wire [`SSP_PIN_COUNT-1:0] next_pin_out;
  wire [`SSP_PIN_COUNT-1:0] next_pin_oe_n;

  // Only serial out is driven in port mode; the other pins are inputs
  assign port_pin_out = {next_tx[`SSP_BYTE_BITS-1], 3'h0};
  assign port_pin_oe_n = {lnk.sel_n, 3'h7};
  assign next_pin_out = slave_port_enable ? port_pin_out : lcd_seg_drive;
  assign next_pin_oe_n = slave_port_enable ? port_pin_oe_n : 4'h0;

  // One flop pair per pin, so every pin leaves straight from a register
  for (genvar p = 0; p < `SSP_PIN_COUNT; p++) begin : g_pin
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        seg_pin_out[p] <= 1'b0;
        seg_pin_oe_n[p] <= 1'b0;
      end else if (clk_en) begin
        seg_pin_out[p] <= next_pin_out[p];
        seg_pin_oe_n[p] <= next_pin_oe_n[p];
      end
    end
  end

endmodule : ssp_slave_port

`default_nettype wire

/* File: tb/ssp_host_model.sv */
// Behavioural SPI host driving the slave port pins
`default_nettype none
module ssp_host_model #(
  parameter int HALF_NS = 80
) (
  // Link pins
  output logic sel_n,
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  task automatic open_frame();
    sel_n = 1'b0;
    #(2 * HALF_NS);
  endtask : open_frame
  // Clock idles low; data set while low, so the slave samples it settled
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #HALF_NS sclk = 1'b1;
      rx[i] = miso;
      #HALF_NS sclk = 1'b0;
    end
  endtask : shift
  // Gap after select rise is above the slave's minimum
  task automatic close_frame();
    #HALF_NS sel_n = 1'b1;
    mosi = ~mosi;
    #(2 * HALF_NS);
  endtask : close_frame
endmodule : ssp_host_model
`default_nettype wire

/* File: tb/ssp_slave_port_sva.sv */
// Checker of the slave port's pin and memory bus behaviour
`default_nettype none
`include "ssp_params.svh"
module ssp_slave_port_sva #(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Port inputs
  input wire logic slave_port_enable,
  input wire logic io_bus_busy,
  input wire logic [`SSP_PIN_COUNT-1:0] lcd_seg_drive,
  input wire logic [`SSP_PIN_COUNT-1:0] seg_pin_in,
  input wire logic mem_ack,
  // Port outputs
  input wire logic [`SSP_PIN_COUNT-1:0] seg_pin_out,
  input wire logic [`SSP_PIN_COUNT-1:0] seg_pin_oe_n,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [`SSP_CMD_BITS-1:0] last_command_reg,
  input wire logic host_command_irq,
  input wire logic port_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_LCD_FOLLOW: assert property (!$past(slave_port_enable) |->
    seg_pin_oe_n == 4'h0 && seg_pin_out == $past(lcd_seg_drive))
    else $error("pins not following segment drive");
  AST_PORT_PINS: assert property ($past(slave_port_enable) |->
    seg_pin_oe_n[2:0] == 3'h7 && seg_pin_out[2:0] == 3'h0)
    else $error("port input pins driven");
  AST_OUT_FLOAT: assert property ((slave_port_enable && seg_pin_in[0]) [*6] |->
    seg_pin_oe_n[3])
    else $error("serial out driven while deselected");
  AST_IO_YIELD: assert property ($rose(mem_req) && mem_addr >= `SSP_IO_BASE &&
    mem_addr <= `SSP_IO_LIMIT |-> !$past(io_bus_busy))
    else $error("I/O request while processor holds bus");
  AST_QUIET: assert property (port_irq |-> last_command_reg[7] &&
    last_command_reg != `SSP_RD_QUIET && last_command_reg != `SSP_WR_QUIET)
    else $error("port interrupt for quiet or other command");
  AST_END_IRQ: assert property (port_irq |-> $past(seg_pin_in[0], 2) ##1 !port_irq)
    else $error("port interrupt not at deselect");
  AST_CMD_IRQ: assert property (host_command_irq |->
    !$past(seg_pin_in[0], 2) ##1 !host_command_irq)
    else $error("command interrupt misplaced");
  AST_SEL_RESET: assert property ($rose(mem_req) |-> !$past(seg_pin_in[0], 4))
    else $error("request while deselected");
  AST_REQ_HOLD: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("request dropped before ack");
  COV_WRITE: cover property (mem_req && mem_we && mem_ack);
  COV_READ: cover property (mem_req && !mem_we && mem_ack);
  COV_PORT_IRQ: cover property (port_irq);
  COV_CMD_IRQ: cover property (host_command_irq);
endmodule : ssp_slave_port_sva
bind ssp_slave_port ssp_slave_port_sva #(.ADDR_W(ADDR_W)) u_sva (
  .clk, .nrst, .slave_port_enable, .io_bus_busy, .lcd_seg_drive, .seg_pin_in, .mem_ack,
  .seg_pin_out, .seg_pin_oe_n, .mem_req, .mem_we, .mem_addr, .last_command_reg,
  .host_command_irq, .port_irq
);
`default_nettype wire

/* File: tb/test_ssp_slave_port.sv */
// Bench of the slave port with host and memory models
`default_nettype none
module test_ssp_slave_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic nrst = 0;
  logic en = 0;
  logic busy = 0;
  logic ack = 0;
  logic tgl = 0;
  logic [3:0] lcd = 4'h0;
  logic [7:0] rdata = 8'h00;
  logic [3:0] pout, poe_n;
  logic [15:0] addr, laddr;
  logic [7:0] wdata, lcmd, rx;
  logic req, we, hirq, pirq, sel_n, sclk, mosi;
  // Released serial out toggles so a float never reads as data
  wire logic sdo = poe_n[3] ? tgl : pout[3];
  logic [7:0] mem [bit [15:0]];
  logic [7:0] dq [2];
  logic [7:0] rq [2];
  int mismatches = 0, compares = 0, hci = 0, pic = 0, cycles = 0, h0, p0;
  always #10 clk = ~clk;
  ssp_host_model host (.sel_n(sel_n), .sclk(sclk), .mosi(mosi), .miso(sdo));
  ssp_slave_port uut (
    .clk(clk), .nrst(nrst), .clk_en(1'b1), .slave_port_enable(en), .io_bus_busy(busy),
    .lcd_seg_drive(lcd), .seg_pin_in({sdo, mosi, sclk, sel_n}), .seg_pin_out(pout),
    .seg_pin_oe_n(poe_n), .mem_req(req), .mem_we(we), .mem_addr(addr),
    .mem_wdata(wdata), .mem_ack(ack), .mem_rdata(rdata), .last_command_reg(lcmd),
    .last_address_reg(laddr), .host_command_irq(hirq), .port_irq(pirq)
  );
  // Memory answers one cycle after each request
  always @(negedge clk) begin
    tgl <= ~tgl;
    ack <= req && !ack;
    if (req && !ack && we) mem[addr] = wdata;
    if (req && !ack && !we) rdata <= mem.exists(addr) ? mem[addr] : 8'hee;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (hirq === 1'b1) hci <= hci + 1;
    if (pirq === 1'b1) pic <= pic + 1;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  // Negative byte count sends the command alone
  task automatic txn(input logic [7:0] c, input logic [15:0] a, input int n);
    h0 = hci;
    p0 = pic;
    host.open_frame();
    host.shift(c, rx);
    if (n >= 0) begin
      host.shift(a[15:8], rx);
      host.shift(a[7:0], rx);
    end
    for (int i = 0; i < n; i++) host.shift(dq[i], rq[i]);
    host.close_frame();
    repeat (4) @(negedge clk);
  endtask : txn
  task automatic t_pins();
    lcd = 4'h9;
    repeat (2) @(negedge clk);
    check(pout, 4'h9);
    check(poe_n, 4'h0);
    en = 1'b1;
    repeat (8) @(negedge clk);
    check(poe_n, 4'hf);
    check(pout[2:0], 3'h0);
    $display("test pins done");
  endtask : t_pins
  task automatic t_write();
    dq = '{8'h5a, 8'hc3};
    txn(8'h85, 16'hf0fe, 2);
    check(mem[16'hf0fe], 8'h5a);
    check(mem[16'hf0ff], 8'hc3);
    check(lcmd, 8'h85);
    check(laddr, 16'hf100);
    check(hci - h0, 1);
    check(pic - p0, 1);
    $display("test write done");
  endtask : t_write
  task automatic t_read();
    mem[16'h0400] = 8'h96;
    mem[16'h0401] = 8'h3b;
    txn(8'hc5, 16'h0400, 2);
    check(rq[0], 8'h96);
    check(rq[1], 8'h3b);
    check(laddr, 16'h0402);
    check(pic - p0, 1);
    $display("test read done");
  endtask : t_read
  task automatic t_quiet();
    dq[0] = 8'h44;
    txn(8'h80, 16'h0500, 1);
    check(pic - p0, 0);
    txn(8'hc0, 16'h0500, 1);
    check(rq[0], 8'h44);
    check(pic - p0, 0);
    check(hci - h0, 1);
    $display("test quiet done");
  endtask : t_quiet
  task automatic t_cmd();
    txn(8'h3c, 16'h0000, -1);
    check(lcmd, 8'h3c);
    check(laddr, 16'h0501);
    check(pic - p0, 0);
    $display("test command done");
  endtask : t_cmd
  task automatic t_io();
    busy = 1'b1;
    txn(8'h01, 16'h0000, -1);
    dq[0] = 8'h77;
    txn(8'h85, 16'h2010, 1);
    check(mem.exists(16'h2010), 0);
    txn(8'hc5, 16'h2010, 1);
    check(rq[0], 8'h00);
    txn(8'h02, 16'h0000, -1);
    busy = 1'b0;
    $display("test io done");
  endtask : t_io
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    t_pins();
    t_write();
    t_read();
    t_quiet();
    t_cmd();
    t_io();
    conclude();
  end
endmodule : test_ssp_slave_port
`default_nettype wire
